// file: core/compare_branch_break_unit.sv
// branch decision, target, slot checks and breakpoint trap
`timescale 1ns/1ps
`include "cbb_regs.svh"
module compare_branch_break_unit import cbb_pkg::*; #(
  parameter int  ADDR_W     = 32,
  parameter bit  NEW_RELEASE = 1'b1
) (
  // clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              SRST,
  // instruction issue
  input  wire logic              ISSUE_VALID,
  input  wire logic [31:0]       INSTR,
  input  wire logic [ADDR_W-1:0] PC,
  input  wire logic [31:0]       SRC_A,
  input  wire logic [31:0]       SRC_B,
  // redirect and slot control
  output logic                   REDIRECT,
  output logic [ADDR_W-1:0]      TARGET,
  output logic                   NULLIFY_SLOT,
  output logic                   PREDICT_TAKEN,
  output logic                   PREDICTOR_BYPASS,
  // exceptions
  output logic                   RESERVED_EXC,
  output logic                   BREAK_EXC,
  output logic [ADDR_W-1:0]      EXC_PC
);
  cbb_dec_if dec ();
  assign dec.instr = INSTR;
  cbb_classify u_classify (.d(dec));

  // ****************************************************************
  // decision logic
  // ****************************************************************
  logic [32:0]       wide_sum;
  logic              ovf;
  logic [ADDR_W-1:0] pc_next;
  logic [ADDR_W-1:0] ofs_ext;
  logic [ADDR_W-1:0] branch_tgt;
  logic              taken;
  logic              is_branch;
  logic              compact;
  logic [4:0]        src2_num;

  // overflow from a 33-bit sum; the sum itself is thrown away
  assign wide_sum = {SRC_A[31], SRC_A} + {SRC_B[31], SRC_B};
  assign ovf      = wide_sum[32] != wide_sum[31];
  assign pc_next  = PC + ADDR_W'(4);
  // shift and sign-extend the 16-bit field into an 18-bit offset
  assign ofs_ext  = ADDR_W'($signed({INSTR[`FLD_OFS_HI:0], 2'b00}));
  assign src2_num = INSTR[`FLD_SRC2_HI:`FLD_SRC2_LO];
  assign branch_tgt = pc_next + ofs_ext;

  // branch condition; for the overflow branches a second source register number of zero is checked
  // directly and forces the outcome, whatever the source values are
  always_comb begin
    taken     = 1'b0;
    is_branch = 1'b1;
    compact   = 1'b0;
    case (dec.kind)
      KIND_NOT_EQUAL:        taken = SRC_A != SRC_B;
      KIND_NOT_EQUAL_LIKELY: taken = SRC_A != SRC_B;
      KIND_BOV: begin
        compact = 1'b1;
        // register zero as second source forces the outcome
        taken   = ovf && (src2_num != 5'h00);
      end
      KIND_BNV: begin
        compact = 1'b1;
        taken   = !ovf || (src2_num == 5'h00);
      end
      default: is_branch = 1'b0;
    endcase
  end

  // ****************************************************************
  // slot and redirect state
  // ****************************************************************
  slot_type          slot_r;
  slot_type          slot_nxt;
  logic              pend_r;
  logic              pend_nxt;
  logic [ADDR_W-1:0] pend_tgt_r;
  logic [ADDR_W-1:0] pend_tgt_nxt;
  logic              redirect_nxt;
  logic [ADDR_W-1:0] target_nxt;
  logic              nullify_nxt;
  logic              pred_nxt;
  logic              bypass_nxt;
  logic              rsv_nxt;
  logic              brk_nxt;
  logic [ADDR_W-1:0] exc_pc_nxt;
  logic              likely_refused;
  logic              slot_trap;

  // the likely branch is withdrawn in the newer release and refused there
  assign likely_refused = NEW_RELEASE
                       && (dec.kind == KIND_NOT_EQUAL_LIKELY);
  // slot state records only the situations that trap; a taken compact
  // branch leaves no forbidden slot behind
  assign slot_trap = ISSUE_VALID && dec.xfer && NEW_RELEASE
                  && (slot_r != SLOT_NONE);

  // next values of slot tracking, redirect and exception outputs
  always_comb begin
    slot_nxt     = slot_r;
    pend_nxt     = pend_r;
    pend_tgt_nxt = pend_tgt_r;
    redirect_nxt = 1'b0;
    target_nxt   = TARGET;
    nullify_nxt  = 1'b0;
    pred_nxt     = 1'b0;
    bypass_nxt   = 1'b0;
    rsv_nxt      = 1'b0;
    brk_nxt      = 1'b0;
    exc_pc_nxt   = EXC_PC;
    if (ISSUE_VALID) begin
      slot_nxt = SLOT_NONE;
      pend_nxt = 1'b0;
      if (slot_trap || likely_refused) begin
        rsv_nxt    = 1'b1;
        exc_pc_nxt = PC;
      end else if (dec.kind == KIND_BREAK) begin
        brk_nxt    = 1'b1; // code field stays in memory
        exc_pc_nxt = PC;
      end else begin
        // delay slot finished: apply the held redirect now
        if (pend_r) begin
          redirect_nxt = 1'b1;
          target_nxt   = pend_tgt_r;
        end
        if (is_branch && compact) begin
          if (taken) begin
            redirect_nxt = 1'b1;
            target_nxt   = branch_tgt;
          end else begin
            slot_nxt = SLOT_FORBID;
          end
        end else if (is_branch) begin
          // plain branch runs its slot unless an untaken likely branch nullifies it; redirect waits for it
          slot_nxt     = SLOT_DELAY;
          pend_nxt     = taken;
          pend_tgt_nxt = branch_tgt;
          if (dec.kind == KIND_NOT_EQUAL_LIKELY) begin
            pred_nxt    = 1'b1;
            bypass_nxt  = 1'b1;
            nullify_nxt = !taken;
            if (!taken) begin
              slot_nxt = SLOT_NONE; // slot squashed, no check needed
            end
          end
        end else if (dec.xfer && (slot_r == SLOT_NONE)) begin
          slot_nxt = SLOT_DELAY; // other transfers own a delay slot too
        end
      end
    end
  end

  // register all state and outputs
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      slot_r           <= SLOT_NONE;
      pend_r           <= 1'b0;
      pend_tgt_r       <= '0;
      REDIRECT         <= 1'b0;
      TARGET           <= '0;
      NULLIFY_SLOT     <= 1'b0;
      PREDICT_TAKEN    <= 1'b0;
      PREDICTOR_BYPASS <= 1'b0;
      RESERVED_EXC     <= 1'b0;
      BREAK_EXC        <= 1'b0;
      EXC_PC           <= '0;
    end else begin
      slot_r           <= slot_nxt;
      pend_r           <= pend_nxt;
      pend_tgt_r       <= pend_tgt_nxt;
      REDIRECT         <= redirect_nxt;
      TARGET           <= target_nxt;
      NULLIFY_SLOT     <= nullify_nxt;
      PREDICT_TAKEN    <= pred_nxt;
      PREDICTOR_BYPASS <= bypass_nxt;
      RESERVED_EXC     <= rsv_nxt;
      BREAK_EXC        <= brk_nxt;
      EXC_PC           <= exc_pc_nxt;
    end
  end
endmodule // compare_branch_break_unit

// file: core/cbb_regs.svh
// constants for the compare, branch and break unit
// What this block does
// - target is next pc plus sign-extended 18-bit offset from 16-bit field
// - not-equal branch redirects when sources differ, after the delay slot
// - likely not-equal runs delay slot only when taken, else nullifies it
// - newer release traps a control transfer executed in a delay slot
// - branches, jumps, link, returns, wait and pause count as transfers
// - control transfer in forbidden slot traps only if branch not taken
// - overflow branches are compact, no delay slot, redirect directly
// - add sources wide, flag overflow when sum bit 32 differs from 31
// - overflow branch taken on overflow, no-overflow branch otherwise
// - second source zero means overflow never, no-overflow always taken
// - overflow branches under opcodes 001000 and 011000, first reg >= second
// - break is opcode 000000 function 001101, traps at once always
// - the 20-bit break code is not passed to the handler
// - likely branches predicted taken, dynamic tables untouched
// - newer release may refuse the likely not-equal branch
`ifndef CBB_REGS_SVH
`define CBB_REGS_SVH
`define OPC_SPECIAL     6'h00
`define OPC_REGIMM      6'h01
`define OPC_J           6'h02
`define OPC_JAL         6'h03
`define OPC_BEQ         6'h04
`define OPC_NOT_EQUAL   6'h05
`define OPC_BLEZ        6'h06
`define OPC_BGTZ        6'h07
`define OPC_GROUP8      6'h08
`define OPC_COP0        6'h10
`define OPC_COP1        6'h11
`define OPC_BEQL        6'h14
`define OPC_NOT_EQUAL_LIKELY 6'h15
`define OPC_BLEZL       6'h16
`define OPC_BGTZL       6'h17
`define OPC_GROUP24     6'h18
`define OPC_BC          6'h32
`define OPC_BALC        6'h3a
`define OPC_POP66       6'h36
`define OPC_POP76       6'h3e
`define OPC_POP26       6'h16
`define FN_JR           6'h08
`define FN_JALR         6'h09
`define FN_BREAK        6'h0d
`define FN_SLL          6'h00
`define FN_EXC_RETURN   6'h18
`define FN_DEBUG_RETURN 6'h1f
`define FN_WAIT         6'h20
`define FLD_OPC_HI      31
`define FLD_OPC_LO      26
`define FLD_SRC1_HI     25
`define FLD_SRC1_LO     21
`define FLD_SRC2_HI     20
`define FLD_SRC2_LO     16
`define FLD_FN_HI       5
`define FLD_FN_LO       0
`define FLD_OFS_HI      15
`define PAUSE_WORD      32'h0000_0140
`define CO_BIT          25
`define NOP_WORD        32'h0000_0000
`endif

// file: core/cbb_pkg.sv
// types for the compare, branch and break unit
package cbb_pkg;
  typedef enum logic [2:0] {
    KIND_NONE  = 3'b000,
    KIND_NOT_EQUAL        = 3'b001,
    KIND_NOT_EQUAL_LIKELY = 3'b010,
    KIND_BOV   = 3'b011,
    KIND_BNV   = 3'b100,
    KIND_BREAK = 3'b101
  } kind_type;
  typedef enum logic [1:0] {
    SLOT_NONE   = 2'b00,
    SLOT_DELAY  = 2'b01,
    SLOT_FORBID = 2'b10
  } slot_type;
endpackage

// file: core/cbb_dec_if.sv
// decode bundle between the top and the instruction classifier
`timescale 1ns/1ps
interface cbb_dec_if;
  logic [31:0]       instr;
  cbb_pkg::kind_type kind;
  logic              xfer;
  modport dec (input instr, output kind, xfer);
  modport use_side (output instr, input kind, xfer);
endinterface

// file: core/cbb_classify.sv
// instruction classifier: kind of branch and control-transfer detection
`timescale 1ns/1ps
`include "cbb_regs.svh"
module cbb_classify import cbb_pkg::*; (
  // decode bundle
  cbb_dec_if.dec d
);
  logic [5:0] opc;
  logic [5:0] fn;
  logic [4:0] src1_num;
  logic [4:0] src2_num;
  assign opc      = d.instr[`FLD_OPC_HI:`FLD_OPC_LO];
  assign fn       = d.instr[`FLD_FN_HI:`FLD_FN_LO];
  assign src1_num = d.instr[`FLD_SRC1_HI:`FLD_SRC1_LO];
  assign src2_num = d.instr[`FLD_SRC2_HI:`FLD_SRC2_LO];

  // kind decode; group opcodes need first reg >= second reg
  always_comb begin
    d.kind = KIND_NONE;
    case (opc)
      `OPC_NOT_EQUAL: d.kind = KIND_NOT_EQUAL;
      `OPC_NOT_EQUAL_LIKELY: d.kind = KIND_NOT_EQUAL_LIKELY;
      `OPC_GROUP8: begin
        if (src1_num >= src2_num) d.kind = KIND_BOV;
      end
      `OPC_GROUP24: begin
        if (src1_num >= src2_num) d.kind = KIND_BNV;
      end
      `OPC_SPECIAL: begin
        if (fn == `FN_BREAK) d.kind = KIND_BREAK;
      end
      default: d.kind = KIND_NONE;
    endcase
  end

  // control-transfer set: branches, jumps, link, returns, wait, pause
  always_comb begin
    d.xfer = 1'b0;
    case (opc)
      `OPC_SPECIAL: begin
        d.xfer = (fn == `FN_JR) || (fn == `FN_JALR)
              || (d.instr == `PAUSE_WORD);
      end
      `OPC_REGIMM, `OPC_J, `OPC_JAL, `OPC_BEQ, `OPC_NOT_EQUAL, `OPC_BLEZ,
      `OPC_BGTZ, `OPC_BEQL, `OPC_NOT_EQUAL_LIKELY, `OPC_BLEZL, `OPC_BGTZL,
      `OPC_BC, `OPC_BALC, `OPC_POP66, `OPC_POP76: d.xfer = 1'b1;
      `OPC_GROUP8, `OPC_GROUP24: d.xfer = (src1_num >= src2_num);
      `OPC_COP0: begin
        d.xfer = d.instr[`CO_BIT] && ((fn == `FN_EXC_RETURN)
              || (fn == `FN_DEBUG_RETURN) || (fn == `FN_WAIT));
      end
      `OPC_COP1: d.xfer = (src1_num == 5'h08) || (src1_num == 5'h09)
                       || (src1_num == 5'h0d);
      default: d.xfer = 1'b0;
    endcase
  end
endmodule // cbb_classify

// file: verification/cbb_props.sv
// port-level assertions for the compare, branch and break unit
`timescale 1ns/1ps
module cbb_props #(
  parameter int ADDR_W      = 32,
  parameter bit NEW_RELEASE = 1'b1
) (
  // clock and reset
  input wire logic              REF_CLK,
  input wire logic              SRST,
  // issue side
  input wire logic              ISSUE_VALID,
  input wire logic [31:0]       INSTR,
  input wire logic [ADDR_W-1:0] PC,
  input wire logic [31:0]       SRC_A,
  input wire logic [31:0]       SRC_B,
  // results
  input wire logic              REDIRECT,
  input wire logic [ADDR_W-1:0] TARGET,
  input wire logic              NULLIFY_SLOT,
  input wire logic              PREDICT_TAKEN,
  input wire logic              PREDICTOR_BYPASS,
  input wire logic              RESERVED_EXC,
  input wire logic              BREAK_EXC,
  input wire logic [ADDR_W-1:0] EXC_PC
);
  logic [32:0]       wsum;
  logic              ovf;
  logic [5:0]        opc;
  logic [ADDR_W-1:0] ofs4;
  // 33-bit sum: bit 32 against bit 31 flags signed overflow
  assign wsum = {SRC_A[31], SRC_A} + {SRC_B[31], SRC_B};
  assign ovf  = wsum[32] ^ wsum[31];
  assign opc  = INSTR[31:26];
  assign ofs4 = ADDR_W'({{14{INSTR[15]}}, INSTR[15:0], 2'b00});
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // a leading nop guarantees the branch does not sit in a slot
  // the slot is a nop as well, so nothing in it can trap
  sequence s_ne_taken;
    ISSUE_VALID && INSTR == 32'h0 ##1
    ISSUE_VALID && opc == 6'h05 && SRC_A != SRC_B ##1
    ISSUE_VALID && INSTR == 32'h0;
  endsequence
  sequence s_bov_taken;
    ISSUE_VALID && INSTR == 32'h0 ##1 ISSUE_VALID && opc == 6'h08
    && INSTR[25:21] >= INSTR[20:16] && INSTR[20:16] != 5'h0 && ovf;
  endsequence
  sequence s_ne_jump;
    ISSUE_VALID && INSTR == 32'h0 ##1 ISSUE_VALID && opc == 6'h05
    ##1 ISSUE_VALID && opc == 6'h02;
  endsequence
  a_ne_waits: assert property (
    ISSUE_VALID && opc == 6'h05 |=> !REDIRECT)
    else $error("branch redirected before its slot");
  a_ne_target: assert property (
    s_ne_taken |=> REDIRECT && TARGET == $past(PC, 2) + 4 + $past(ofs4, 2))
    else $error("taken branch target wrong");
  a_slot_trap: assert property (
    s_ne_jump |=> !NEW_RELEASE || RESERVED_EXC && !REDIRECT
    && EXC_PC == $past(PC))
    else $error("transfer in delay slot not trapped");
  a_bov_taken: assert property (
    s_bov_taken |=> REDIRECT && TARGET == $past(PC) + 4 + $past(ofs4))
    else $error("overflow branch not taken at once");
  a_bnv_rt_zero: assert property (
    ISSUE_VALID && INSTR == 32'h0 ##1 ISSUE_VALID && opc == 6'h18
    && INSTR[20:16] == 5'h0 |=> REDIRECT)
    else $error("no-overflow branch on zero not taken");
  a_bov_rt_zero: assert property (
    ISSUE_VALID && opc == 6'h08 && INSTR[20:16] == 5'h0 |=> !REDIRECT)
    else $error("overflow branch on zero taken");
  a_forbid_taken: assert property (
    s_bov_taken ##1 ISSUE_VALID && opc == 6'h02 |=> !RESERVED_EXC)
    else $error("forbidden slot trapped after taken branch");
  a_break_trap: assert property (
    ISSUE_VALID && opc == 6'h00 && INSTR[5:0] == 6'h0d
    |=> BREAK_EXC && !REDIRECT && EXC_PC == $past(PC))
    else $error("breakpoint not raised");
  a_likely_refused: assert property (
    ISSUE_VALID && opc == 6'h15 |=> !NEW_RELEASE || RESERVED_EXC)
    else $error("likely branch accepted on new release");
endmodule // cbb_props
bind compare_branch_break_unit cbb_props #(
  .ADDR_W(ADDR_W), .NEW_RELEASE(NEW_RELEASE)) u_props (
  .REF_CLK(REF_CLK), .SRST(SRST), .ISSUE_VALID(ISSUE_VALID),
  .INSTR(INSTR), .PC(PC), .SRC_A(SRC_A), .SRC_B(SRC_B),
  .REDIRECT(REDIRECT), .TARGET(TARGET), .NULLIFY_SLOT(NULLIFY_SLOT),
  .PREDICT_TAKEN(PREDICT_TAKEN), .PREDICTOR_BYPASS(PREDICTOR_BYPASS),
  .RESERVED_EXC(RESERVED_EXC), .BREAK_EXC(BREAK_EXC), .EXC_PC(EXC_PC));

// file: verification/fetch_model.sv
// fetch side model: counts redirects and keeps the last target
`timescale 1ns/1ps
module fetch_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // redirect from the unit
  input  wire logic        redirect,
  input  wire logic [31:0] target,
  // observed state
  output logic [7:0]       n_redirect,
  output logic [31:0]      last_target
);
  // only the pulse moves fetch; target alone may be stale
  always_ff @(posedge clk) begin
    if (rst) begin
      n_redirect  <= 8'h00;
      last_target <= 32'h0000_0000;
    end else if (redirect) begin
      n_redirect  <= n_redirect + 8'h01;
      last_target <= target;
    end
  end
endmodule // fetch_model

// file: verification/compare_branch_break_unit_bench.sv
// self-checking bench for the compare, branch and break unit
`timescale 1ns/1ps
module compare_branch_break_unit_bench;
  logic        ref_clk, srst, iv, redir, nul, pt, pb, rexc, bexc;
  logic [31:0] instr, pc, a, b, tgt, epc, f_tgt;
  logic [7:0]  f_cnt;
  logic        o_redir, o_nul, o_pt, o_pb;
  logic [31:0] o_tgt;
  int          n_fail, samples_checked;
  compare_branch_break_unit u_dut (
    .REF_CLK(ref_clk), .SRST(srst), .ISSUE_VALID(iv), .INSTR(instr),
    .PC(pc), .SRC_A(a), .SRC_B(b), .REDIRECT(redir), .TARGET(tgt),
    .NULLIFY_SLOT(nul), .PREDICT_TAKEN(pt), .PREDICTOR_BYPASS(pb),
    .RESERVED_EXC(rexc), .BREAK_EXC(bexc), .EXC_PC(epc));
  fetch_model u_fetch (.clk(ref_clk), .rst(srst), .redirect(redir),
    .target(tgt), .n_redirect(f_cnt), .last_target(f_tgt));
  // older release twin: the likely branch is still accepted there
  compare_branch_break_unit #(.NEW_RELEASE(1'b0)) u_old (
    .REF_CLK(ref_clk), .SRST(srst), .ISSUE_VALID(iv), .INSTR(instr),
    .PC(pc), .SRC_A(a), .SRC_B(b), .REDIRECT(o_redir), .TARGET(o_tgt),
    .NULLIFY_SLOT(o_nul), .PREDICT_TAKEN(o_pt), .PREDICTOR_BYPASS(o_pb),
    .RESERVED_EXC(), .BREAK_EXC(), .EXC_PC());
  // *****************************
  // drivers and compare
  // *****************************
  // one instruction per call; results visible on return
  task automatic issue(input logic [31:0] w, p, x, y);
    {iv, instr, pc, a, b} = {1'b1, w, p, x, y};
    @(negedge ref_clk);
  endtask
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // *****************************
  // scenarios
  // *****************************
  task automatic t_not_equal;
    issue(32'h0, 32'h0003_fffc, 32'h0, 32'h0);
    issue(32'h1422_8000, 32'h0004_0000, 32'h1, 32'h2);
    chk(redir, 32'h0);
    issue(32'h0, 32'h0004_0004, 32'h0, 32'h0);
    chk(redir, 32'h1);
    chk(tgt, 32'h0002_0004);
    issue(32'h1422_0010, 32'h0000_0100, 32'h5, 32'h5);
    // fetch takes the pulse one edge after it appears
    chk(f_tgt, 32'h0002_0004);
    chk(f_cnt, 32'h1);
    issue(32'h0, 32'h0000_0104, 32'h0, 32'h0);
    chk({redir, nul}, 32'h0);
    $display("test not-equal done");
  endtask
  task automatic t_slot;
    logic [31:0] xfer [8] = '{32'h0800_0000, 32'h0000_0140, 32'h4200_0018,
      32'h4200_0058, 32'h4200_001f, 32'h4200_0020, 32'h0410_0000,
      32'h03e0_0008};
    foreach (xfer[i]) begin
      issue(32'h1422_0001, 32'h0000_1000, 32'h1, 32'h2);
      issue(xfer[i], 32'h0000_1004, 32'h0, 32'h0);
      chk({redir, rexc}, 32'h1);
      chk(epc, 32'h0000_1004);
      repeat (2) issue(32'h0, 32'h0, 32'h0, 32'h0);
    end
    $display("test slot done");
  endtask
  task automatic t_likely;
    issue(32'h5422_0004, 32'h0000_2000, 32'h1, 32'h2);
    chk(rexc, 32'h1);
    chk(epc, 32'h0000_2000);
    chk({pt, pb}, 32'h0);
    repeat (2) issue(32'h0, 32'h0, 32'h0, 32'h0);
    $display("test likely done");
  endtask
  // older release: taken likely branch keeps its slot, untaken squashes it
  task automatic t_likely_old;
    issue(32'h5422_0004, 32'h0000_2000, 32'h1, 32'h2);
    chk({o_pt, o_pb, o_nul}, 32'h6);
    issue(32'h0, 32'h0000_2004, 32'h0, 32'h0);
    chk(o_redir, 32'h1);
    chk(o_tgt, 32'h0000_2014);
    issue(32'h5422_0004, 32'h0000_2008, 32'h3, 32'h3);
    chk({o_pt, o_pb, o_nul}, 32'h7);
    issue(32'h0, 32'h0000_200c, 32'h0, 32'h0);
    chk(o_redir, 32'h0);
    $display("test likely old release done");
  endtask
  task automatic t_ovf;
    logic [31:0] w [8] = '{32'h2041_0010, 32'h6041_0010, 32'h2041_0010,
      32'h2041_0010, 32'h6041_0010, 32'h2040_0010, 32'h6040_0010,
      32'h6000_0010};
    logic [31:0] x [8] = '{32'h7fff_ffff, 32'h7fff_ffff, 32'h8000_0000,
      32'h7fff_fffe, 32'h7fff_fffe, 32'h7fff_ffff, 32'h7fff_ffff,
      32'h7fff_ffff};
    logic [31:0] y [8] = '{32'h1, 32'h1, 32'hffff_ffff, 32'h1, 32'h1,
      32'h1, 32'h1, 32'h7fff_ffff};
    logic [7:0] e = 8'b1101_0101;
    foreach (w[i]) begin
      issue(32'h0, 32'h0, 32'h0, 32'h0);
      issue(w[i], 32'h0000_3000, x[i], y[i]);
      // bit i of e is the outcome of entry i
      chk(redir, e[i]);
      if (e[i]) chk(tgt, 32'h0000_3044);
    end
    issue(32'h0, 32'h0, 32'h0, 32'h0);
    $display("test overflow done");
  endtask
  task automatic t_forbid;
    for (int i = 0; i < 2; i++) begin
      issue(i ? 32'h2041_0010 : 32'h6041_0010, 32'h0000_3000,
        32'h7fff_ffff, 32'h1);
      issue(32'h0800_0000, 32'h0000_3004, 32'h0, 32'h0);
      chk(rexc, i ? 32'h0 : 32'h1);
      repeat (2) issue(32'h0, 32'h0, 32'h0, 32'h0);
    end
    $display("test forbidden slot done");
  endtask
  task automatic t_break;
    issue(32'h0123_450d, 32'h0000_5000, 32'h0, 32'h0);
    chk({redir, bexc}, 32'h1);
    chk(epc, 32'h0000_5000);
    issue(32'h3400_000d, 32'h0000_5004, 32'h0, 32'h0);
    chk(bexc, 32'h0);
    // a held break word without issue must stay silent
    {iv, instr} = {1'b0, 32'h0000_000d};
    @(negedge ref_clk);
    chk(bexc, 32'h0);
    $display("test break done");
  endtask
  // clock and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    {srst, iv, instr, pc, a, b} = {1'b1, 1'b0, 128'h0};
    repeat (10) @(negedge ref_clk);
    srst = 1'b0;
    t_not_equal();
    t_slot();
    t_likely();
    t_likely_old();
    t_ovf();
    t_forbid();
    t_break();
    stop_test();
  end
  // the whole run needs under a hundred cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    $display("watchdog expired");
    stop_test();
  end
endmodule // compare_branch_break_unit_bench
